// ==== hw/rssa_pkg.sv ====
// rssa_pkg: constants and types of the rotate/subtract/swap datapath
// assumes one core clock, operands driven by the core decoder
// Function
// - rotate right moves bits down, old bit 0 into carry, carry into bit 7
// - destination bit 0 writes accumulator, 1 writes the file register
// - sleep clears the watchdog counter and its prescaler
// - sleep clears powerdown flag, sets timeout flag, touches no other flag
// - literal minus accumulator, two's complement, difference into accumulator
// - literal subtract carry and half carry are no-borrow compares
// - register minus accumulator, carry and half carry as no-borrow compares
// - borrow subtract also removes inverted carry, updates carry, half carry, zero
// - nibble swap exchanges the nibbles and leaves all flags alone
package rssa_pkg;
  localparam int RSSA_DW = 8;
  localparam logic [31:0] RSSA_ACC_OFS = 32'h0000_0000;
  localparam logic [31:0] RSSA_STAT_OFS = 32'h0000_0004;
  localparam int RSSA_STAT_C = 0;
  localparam int RSSA_STAT_DC = 1;
  localparam int RSSA_STAT_Z = 2;
  localparam int RSSA_STAT_PD = 3;
  localparam int RSSA_STAT_TO = 4;
  localparam logic [7:0] RSSA_ACC_RST = 8'h00;
  localparam logic RSSA_FLAG_RST = 1'b0;
  localparam logic RSSA_PWR_FLAG_RST = 1'b1;
  typedef enum logic [5:0] {
    RSSA_OP_ROTATE = 6'b00_0001,
    RSSA_OP_LIT_SUB = 6'b00_0010,
    RSSA_OP_REG_SUB = 6'b00_0100,
    RSSA_OP_BRW_SUB = 6'b00_1000,
    RSSA_OP_SWAP = 6'b01_0000,
    RSSA_OP_SLEEP = 6'b10_0000
  } rssa_op_t;
endpackage

// ==== hw/rssa_sub_if.sv ====
// rssa_sub_if: operands and results of the subtractor
// assumes the main datapath drives the operands combinationally
`timescale 1ns/100ps
`default_nettype none
interface rssa_sub_if;
  logic [7:0] minuend;
  logic [7:0] subtrahend;
  logic borrow_in;
  logic [7:0] diff;
  logic carry_out;
  logic half_carry_out;
  modport user (output minuend, output subtrahend, output borrow_in,
    input diff, input carry_out, input half_carry_out);
  modport sub (input minuend, input subtrahend, input borrow_in,
    output diff, output carry_out, output half_carry_out);
endinterface
`default_nettype wire

// ==== hw/rssa_sub.sv ====
// rssa_sub: 8-bit two's complement subtractor with no-borrow flags
// assumes operands stable within the cycle
`timescale 1ns/100ps
`default_nettype none
module rssa_sub
  import rssa_pkg::*;
(
  rssa_sub_if.sub sb
);
  logic [8:0] full_diff;
  logic [4:0] low_diff;
  // carry is the inverted borrow out of each width
  always_comb
  begin
    full_diff = {1'b0, sb.minuend} - {1'b0, sb.subtrahend} - {8'h00, sb.borrow_in};
    low_diff = {1'b0, sb.minuend[3:0]} - {1'b0, sb.subtrahend[3:0]} - {4'h0, sb.borrow_in};
  end
  assign sb.diff = full_diff[7:0];
  assign sb.carry_out = ~full_diff[8];
  assign sb.half_carry_out = ~low_diff[4];
endmodule
`default_nettype wire

// ==== hw/rssa_alu.sv ====
// rssa_alu: rotate, subtract, swap and sleep effects of the core
// assumes decoder presents one operation per cycle with op_valid
`timescale 1ns/100ps
`default_nettype none
module rssa_alu
  import rssa_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic op_valid,
  input wire rssa_op_t op_code,
  input wire logic dest_bit,
  input wire logic [7:0] file_data,
  input wire logic [7:0] literal,
  output logic [7:0] acc_reg,
  output logic carry_reg,
  output logic half_carry_flag_reg,
  output logic zero_reg,
  output logic timeout_flag_reg,
  output logic powerdown_flag_reg,
  output logic file_wr_en_reg,
  output logic [7:0] file_wr_data_reg,
  output logic watchdog_counter_clear_reg,
  output logic prescaler_clear_reg,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  rssa_sub_if sub_bus ();
  logic [7:0] result_next;
  logic carry_next;
  logic half_carry_next;
  logic zero_next;
  logic flags_sub;
  logic rotate_now;
  logic sleep_now;
  logic result_now;
  logic apb_write;
  logic apb_setup;

  rssa_sub u_sub (
    .sb(sub_bus.sub)
  );

  // subtractor operand select
  always_comb
  begin
    sub_bus.minuend = file_data;
    sub_bus.subtrahend = acc_reg;
    sub_bus.borrow_in = 1'b0;
    if (op_code == RSSA_OP_LIT_SUB)
    begin
      sub_bus.minuend = literal;
    end
    if (op_code == RSSA_OP_BRW_SUB)
    begin
      sub_bus.borrow_in = ~carry_reg;
    end
  end

  // result and flag next values
  always_comb
  begin
    result_next = file_data;
    carry_next = carry_reg;
    half_carry_next = half_carry_flag_reg;
    zero_next = zero_reg;
    flags_sub = 1'b0;
    unique case (op_code)
      RSSA_OP_ROTATE:
      begin
        result_next = {carry_reg, file_data[7:1]};
        carry_next = file_data[0];
      end
      RSSA_OP_LIT_SUB, RSSA_OP_REG_SUB, RSSA_OP_BRW_SUB:
      begin
        flags_sub = 1'b1;
        result_next = sub_bus.diff;
        carry_next = sub_bus.carry_out;
        half_carry_next = sub_bus.half_carry_out;
        zero_next = (sub_bus.diff == 8'h00);
      end
      RSSA_OP_SWAP:
      begin
        result_next = {file_data[3:0], file_data[7:4]};
      end
      RSSA_OP_SLEEP:
      begin
        result_next = file_data;
      end
      default:
      begin
        result_next = file_data;
      end
    endcase
  end

  assign rotate_now = op_valid && (op_code == RSSA_OP_ROTATE);
  assign sleep_now = op_valid && (op_code == RSSA_OP_SLEEP);
  assign result_now = op_valid && (op_code inside {RSSA_OP_ROTATE, RSSA_OP_LIT_SUB,
    RSSA_OP_REG_SUB, RSSA_OP_BRW_SUB, RSSA_OP_SWAP});
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pready && pwrite;

  // accumulator: literal subtract always, rotate, other subtracts and swap by destination bit, never on sleep
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acc_reg <= RSSA_ACC_RST;
    end
    else if (result_now && (op_code == RSSA_OP_LIT_SUB || !dest_bit))
    begin
      acc_reg <= result_next;
    end
    else if (apb_write && paddr == RSSA_ACC_OFS)
    begin
      acc_reg <= pwdata[7:0];
    end
  end

  // file register write-back
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      file_wr_en_reg <= 1'b0;
      file_wr_data_reg <= RSSA_ACC_RST;
    end
    else
    begin
      file_wr_en_reg <= result_now && op_code != RSSA_OP_LIT_SUB && dest_bit;
      file_wr_data_reg <= result_next;
    end
  end

  // arithmetic flags
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      carry_reg <= RSSA_FLAG_RST;
      half_carry_flag_reg <= RSSA_FLAG_RST;
      zero_reg <= RSSA_FLAG_RST;
    end
    else if (op_valid && (flags_sub || rotate_now))
    begin
      carry_reg <= carry_next;
      half_carry_flag_reg <= half_carry_next;
      zero_reg <= zero_next;
    end
  end

  // power status flags and watchdog clears
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      timeout_flag_reg <= RSSA_PWR_FLAG_RST;
      powerdown_flag_reg <= RSSA_PWR_FLAG_RST;
      watchdog_counter_clear_reg <= 1'b0;
      prescaler_clear_reg <= 1'b0;
    end
    else
    begin
      watchdog_counter_clear_reg <= sleep_now;
      prescaler_clear_reg <= sleep_now;
      if (sleep_now)
      begin
        timeout_flag_reg <= 1'b1;
        powerdown_flag_reg <= 1'b0;
      end
    end
  end

  // apb slave, answers in the first access cycle
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= apb_setup;
      pslverr <= apb_setup && paddr != RSSA_ACC_OFS && paddr != RSSA_STAT_OFS;
      prdata <= 32'h0000_0000;
      if (apb_setup && !pwrite && paddr == RSSA_ACC_OFS)
      begin
        prdata <= {24'h00_0000, acc_reg};
      end
      else if (apb_setup && !pwrite && paddr == RSSA_STAT_OFS)
      begin
        prdata[RSSA_STAT_C] <= carry_reg;
        prdata[RSSA_STAT_DC] <= half_carry_flag_reg;
        prdata[RSSA_STAT_Z] <= zero_reg;
        prdata[RSSA_STAT_PD] <= powerdown_flag_reg;
        prdata[RSSA_STAT_TO] <= timeout_flag_reg;
      end
    end
  end

  a_rotate_result: assert property (@(posedge clock) disable iff (!reset_n)
    (rotate_now && !dest_bit) |=> acc_reg == {$past(carry_reg), $past(file_data[7:1])}
      && carry_reg == $past(file_data[0]))
    else $error("rotate result or carry wrong");
  a_dest_select: assert property (@(posedge clock) disable iff (!reset_n)
    (result_now && op_code != RSSA_OP_LIT_SUB) |=> file_wr_en_reg == $past(dest_bit))
    else $error("destination select wrong");
  a_sleep_clears: assert property (@(posedge clock) disable iff (!reset_n)
    sleep_now |=> watchdog_counter_clear_reg && prescaler_clear_reg ##1
      !watchdog_counter_clear_reg || $past(sleep_now))
    else $error("sleep clear pulse wrong");
  a_sleep_power: assert property (@(posedge clock) disable iff (!reset_n)
    sleep_now |=> timeout_flag_reg && !powerdown_flag_reg && $stable(carry_reg)
      && $stable(zero_reg) && $stable(half_carry_flag_reg) && $stable(acc_reg))
    else $error("sleep changed wrong flags");
  a_lit_sub: assert property (@(posedge clock) disable iff (!reset_n)
    (op_valid && op_code == RSSA_OP_LIT_SUB) |=>
      acc_reg == 8'($past(literal) - $past(acc_reg)))
    else $error("literal subtract wrong");
  a_lit_carry: assert property (@(posedge clock) disable iff (!reset_n)
    (op_valid && op_code == RSSA_OP_LIT_SUB) |=>
      carry_reg == ($past(acc_reg) <= $past(literal))
      && half_carry_flag_reg == ($past(acc_reg[3:0]) <= $past(literal[3:0])))
    else $error("literal subtract flags wrong");
  a_reg_carry: assert property (@(posedge clock) disable iff (!reset_n)
    (op_valid && op_code == RSSA_OP_REG_SUB && dest_bit) |=>
      file_wr_data_reg == 8'($past(file_data) - $past(acc_reg))
      && carry_reg == ($past(acc_reg) <= $past(file_data)))
    else $error("register subtract wrong");
  a_borrow_sub: assert property (@(posedge clock) disable iff (!reset_n)
    (op_valid && op_code == RSSA_OP_BRW_SUB && dest_bit) |=> file_wr_data_reg ==
      8'($past(file_data) - $past(acc_reg) - {7'h00, !$past(carry_reg)}))
    else $error("borrow subtract wrong");
  a_swap_flags: assert property (@(posedge clock) disable iff (!reset_n)
    (op_valid && op_code == RSSA_OP_SWAP) |=> $stable(carry_reg) && $stable(zero_reg)
      && file_wr_data_reg == {$past(file_data[3:0]), $past(file_data[7:4])})
    else $error("swap wrong");
  a_zero_flag: assert property (@(posedge clock) disable iff (!reset_n)
    (op_valid && flags_sub) |=> zero_reg == ($past(sub_bus.diff) == 8'h00))
    else $error("zero flag wrong");
  a_one_cycle: assert property (@(posedge clock) disable iff (!reset_n)
    (result_now && dest_bit && op_code != RSSA_OP_LIT_SUB) |=> file_wr_en_reg
      ##1 (!file_wr_en_reg || $past(result_now)))
    else $error("write-back not single cycle");
endmodule
`default_nettype wire

// ==== tb/rssa_file_model.sv ====
// rssa_file_model: addressed file register seen by the datapath
// assumes bench loads it before each operation
`timescale 1ns/100ps
`default_nettype none
module rssa_file_model
(
  input wire logic clock,
  input wire logic load_en,
  input wire logic [7:0] load_data,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] file_data
);
  always_ff @(posedge clock)
  begin
    if (load_en)
      file_data <= load_data;
    else if (wr_en)
      file_data <= wr_data;
  end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// testbench: random and corner operations, registers read over apb
// assumes rssa_alu with zero wait state apb
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module testbench
  import rssa_pkg::*;
;
  logic clock = 0, reset_n = 0, op_valid = 0, dest_bit = 0, load_en = 0;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [7:0] literal = 0, load_data = 0, file_data, acc_reg, file_wr_data_reg;
  logic [31:0] paddr = 0, pwdata = 0, prdata;
  logic carry_reg, half_carry_flag_reg, zero_reg, timeout_flag_reg, powerdown_flag_reg;
  logic file_wr_en_reg, watchdog_counter_clear_reg, prescaler_clear_reg, pready, pslverr;
  rssa_op_t op_code = RSSA_OP_SWAP;
  logic [7:0] m_acc = 0;
  logic m_c = 0, m_dc = 0, m_z = 0, m_pd = 1, m_to = 1;
  int n_errors = 0, checked = 0;
  rssa_op_t ops[6] = '{RSSA_OP_ROTATE, RSSA_OP_LIT_SUB, RSSA_OP_REG_SUB,
    RSSA_OP_BRW_SUB, RSSA_OP_SWAP, RSSA_OP_SLEEP};
  always #5 clock = ~clock;
  rssa_alu i_rssa_alu (.clock(clock), .reset_n(reset_n), .op_valid(op_valid),
    .op_code(op_code), .dest_bit(dest_bit), .file_data(file_data), .literal(literal),
    .acc_reg(acc_reg), .carry_reg(carry_reg), .half_carry_flag_reg(half_carry_flag_reg),
    .zero_reg(zero_reg), .timeout_flag_reg(timeout_flag_reg),
    .powerdown_flag_reg(powerdown_flag_reg), .file_wr_en_reg(file_wr_en_reg),
    .file_wr_data_reg(file_wr_data_reg), .watchdog_counter_clear_reg(watchdog_counter_clear_reg),
    .prescaler_clear_reg(prescaler_clear_reg), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  rssa_file_model i_rssa_file_model (.clock(clock), .load_en(load_en),
    .load_data(load_data), .wr_en(file_wr_en_reg), .wr_data(file_wr_data_reg),
    .file_data(file_data));
  task automatic complete_run();
    if (n_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1;
    do
    begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      n_errors++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  function automatic logic [7:0] sub(input logic [7:0] a, input logic [7:0] b, input int bi);
    m_c = int'(a) >= int'(b) + bi;
    m_dc = int'(a[3:0]) >= int'(b[3:0]) + bi;
    sub = a - b - 8'(bi);
    m_z = sub == 8'h00;
  endfunction
  task automatic run_op(input rssa_op_t op, input logic d, input logic [7:0] f,
    input logic [7:0] k);
    logic [7:0] r;
    logic we;
    r = m_acc;
    we = 0;
    @(posedge clock);
    load_en <= 1;
    load_data <= f;
    @(posedge clock);
    load_en <= 0;
    op_valid <= 1;
    op_code <= op;
    dest_bit <= d;
    literal <= k;
    @(posedge clock);
    op_valid <= 0;
    case (op)
      RSSA_OP_ROTATE:
      begin
        r = {m_c, f[7:1]};
        m_c = f[0];
        we = d;
      end
      RSSA_OP_LIT_SUB: r = sub(k, m_acc, 0);
      RSSA_OP_REG_SUB: r = sub(f, m_acc, 0);
      RSSA_OP_BRW_SUB: r = sub(f, m_acc, int'(!m_c));
      RSSA_OP_SWAP: r = {f[3:0], f[7:4]};
      RSSA_OP_SLEEP:
      begin
        m_pd = 0;
        m_to = 1;
      end
      default: ;
    endcase
    if (op inside {RSSA_OP_ROTATE, RSSA_OP_REG_SUB, RSSA_OP_BRW_SUB, RSSA_OP_SWAP})
      we = d;
    if (!we && op != RSSA_OP_SLEEP)
      m_acc = r;
    #1;
    `CHK("file_wr_en", we, file_wr_en_reg)
    if (we)
      `CHK("file_wr_data", r, file_wr_data_reg)
    `CHK("wdt_clear", op == RSSA_OP_SLEEP, watchdog_counter_clear_reg)
    `CHK("pre_clear", op == RSSA_OP_SLEEP, prescaler_clear_reg)
    @(posedge clock);
    #1;
    `CHK("pulse_end", 2'b00, {file_wr_en_reg, watchdog_counter_clear_reg})
  endtask
  task automatic check_regs();
    logic [31:0] rd;
    logic e;
    apb(0, RSSA_ACC_OFS, 0, rd, e);
    `CHK("acc", {24'h0000_00, m_acc}, rd)
    apb(0, RSSA_STAT_OFS, 0, rd, e);
    `CHK("status", {27'h0, m_to, m_pd, m_z, m_dc, m_c}, rd)
  endtask
  logic [7:0] hf[7] = '{8'h05, 8'h00, 8'h00, 8'h22, 8'h01, 8'hA5, 8'h3C};
  logic [7:0] hk[7] = '{8'h00, 8'h40, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] ha[7] = '{8'h03, 8'h40, 8'h21, 8'h11, 8'h80, 8'h77, 8'h5A};
  int ho[7] = '{2, 1, 1, 3, 0, 4, 5};
  initial
  begin
    logic [31:0] rd, wd;
    logic e;
    void'($urandom(32'h2709));
    repeat (2) @(posedge clock);
    reset_n <= 1;
    check_regs();
    apb(0, 32'h0000_0010, 0, rd, e);
    `CHK("unmapped_err", 1'b1, e)
    `CHK("unmapped_data", 32'h0000_0000, rd)
    apb(1, RSSA_STAT_OFS, 32'hFFFF_FFFF, rd, e);
    `CHK("status_wr_err", 1'b0, e)
    for (int i = 0; i < 60; i++)
    begin
      wd = (i < 7) ? {24'hFFFF_FF, ha[i]} : $urandom();
      apb(1, RSSA_ACC_OFS, wd, rd, e);
      m_acc = wd[7:0];
      if (i < 7)
        run_op(ops[ho[i]], i[0], hf[i], hk[i]);
      else if (i % 13 == 0)
        run_op(rssa_op_t'(6'b00_0011), 1'b0, 8'h00, 8'h00);
      else
        run_op(ops[$urandom_range(0, 5)], 1'($urandom()), 8'($urandom()), 8'($urandom()));
      check_regs();
    end
    complete_run();
  end
endmodule
`default_nettype wire
